// ### src/jtsw_tap.sv
// Test access port controller, shift chains, serial-wire switch and pad select
`timescale 1ns/1ps
`default_nettype none
module jtsw_tap
  import jtsw_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = 32'h1234_5677 // Arbitrary identification value
) (
  input wire logic clock, // System clock, 20 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic tck, // Test clock pin
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data in pin
  input wire logic trst_n, // Test reset pin, active low
  output logic tdo, // Test data out pin
  output logic tdo_oe, // Test data out enable
  output logic swd_enable, // Serial-wire mode selected
  output logic [jtsw_pkg::PAD_N-1:0] pad_alt_function_select, // Pin function select
  output logic [jtsw_pkg::PAD_N-1:0] pad_pullup_enable, // Pin pull-up enable
  output logic [jtsw_pkg::TAP_BUS_W-1:0] acc_request, // Last updated access word
  output logic acc_strobe, // One-cycle pulse on access update outside serial-wire mode
  input wire logic [jtsw_pkg::AV_ADDR_W-1:0] avs_address, // Register byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest // Wait request
);
  import jtsw_pkg::*;

  // Elaboration checks: chain widths and pad fields are fixed by the logic below
  if (IR_W != 4) begin : g_bad_ir
    $error("jtsw_tap: instruction width must be 4");
  end
  if (ACC_W != TAP_BUS_W + ACK_W) begin : g_bad_acc
    $error("jtsw_tap: access chain must hold data and acknowledge");
  end
  if (PAD_N > PAD_PU_LSB - PAD_SEL_LSB) begin : g_bad_pad
    $error("jtsw_tap: pad fields overlap in the pad register");
  end
  if (ST_IR_LSB + IR_W > TAP_BUS_W) begin : g_bad_status
    $error("jtsw_tap: status word too narrow");
  end

  // Two-stage synchronisers, one per pin, plus a third stage for edge finding.
  // The reset level matches the pad pull-ups, so no false TCK edge follows reset.
  localparam int PIN_N = 4;
  wire [PIN_N-1:0] pin_raw = {trst_n, tdi, tms, tck};
  wire [PIN_N-1:0] pin_sync;
  wire [PIN_N-1:0] pin_last;
  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
    logic meta;
    logic sync;
    logic last;
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        meta <= 1'b1;
        sync <= 1'b1;
        last <= 1'b1;
      end else begin
        meta <= pin_raw[gi];
        sync <= meta;
        last <= sync;
      end
    end
    assign pin_sync[gi] = sync;
    assign pin_last[gi] = last;
  end
  // TMS and TDI are taken one stage later so they line up with the TCK edge
  wire tms_d = pin_last[1];
  wire tdi_d = pin_last[2];
  wire tck_rise = pin_sync[0] & ~pin_last[0];
  wire tck_fall = ~pin_sync[0] & pin_last[0];
  // Test reset acts as a level; it needs the synchroniser but no edge
  wire test_reset = ~pin_sync[3];

  jtsw_tap_t state, next_state;
  always_comb begin
    case (state)
      JTSW_TLR: next_state = tms_d ? JTSW_TLR : JTSW_RTI;
      JTSW_RTI: next_state = tms_d ? JTSW_SEL_DR : JTSW_RTI;
      JTSW_SEL_DR: next_state = tms_d ? JTSW_SEL_IR : JTSW_CAP_DR;
      JTSW_CAP_DR: next_state = tms_d ? JTSW_EX1_DR : JTSW_SH_DR;
      JTSW_SH_DR: next_state = tms_d ? JTSW_EX1_DR : JTSW_SH_DR;
      JTSW_EX1_DR: next_state = tms_d ? JTSW_UPD_DR : JTSW_PA_DR;
      JTSW_PA_DR: next_state = tms_d ? JTSW_EX2_DR : JTSW_PA_DR;
      JTSW_EX2_DR: next_state = tms_d ? JTSW_UPD_DR : JTSW_SH_DR;
      JTSW_UPD_DR: next_state = tms_d ? JTSW_SEL_DR : JTSW_RTI;
      JTSW_SEL_IR: next_state = tms_d ? JTSW_TLR : JTSW_CAP_IR;
      JTSW_CAP_IR: next_state = tms_d ? JTSW_EX1_IR : JTSW_SH_IR;
      JTSW_SH_IR: next_state = tms_d ? JTSW_EX1_IR : JTSW_SH_IR;
      JTSW_EX1_IR: next_state = tms_d ? JTSW_UPD_IR : JTSW_PA_IR;
      JTSW_PA_IR: next_state = tms_d ? JTSW_EX2_IR : JTSW_PA_IR;
      JTSW_EX2_IR: next_state = tms_d ? JTSW_UPD_IR : JTSW_SH_IR;
      JTSW_UPD_IR: next_state = tms_d ? JTSW_SEL_DR : JTSW_RTI;
      default: next_state = JTSW_TLR;
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) state <= JTSW_TLR;
    else if (test_reset) state <= JTSW_TLR;
    else if (tck_rise) state <= next_state;
  end

  // Instruction register and its decode
  logic [IR_W-1:0] ir_shift, ir;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir_shift <= '0;
      ir <= IR_IDENT;
    end else if (test_reset || state == JTSW_TLR) begin
      ir <= IR_IDENT;
    end else if (tck_rise) begin
      if (state == JTSW_CAP_IR) ir_shift <= {2'b00, IR_CAPTURE};
      else if (state == JTSW_SH_IR) ir_shift <= {tdi_d, ir_shift[IR_W-1:1]};
      if (state == JTSW_UPD_IR) ir <= ir_shift;
    end
  end
  wire sel_ident = (ir == IR_IDENT);
  wire sel_acc = (ir == IR_DPACC) || (ir == IR_APACC);
  wire sel_abort = (ir == IR_ABORT);
  wire sel_bscan = (ir == IR_SAMPLE) || (ir == IR_EXTEST) || (ir == IR_INTEST);
  wire sel_bypass = !(sel_ident || sel_acc || sel_abort || sel_bscan);

  // Data chains: one wide shifter, length picked by the instruction
  logic [ACC_W-1:0] dr_shift;
  logic [TAP_BUS_W-1:0] acc_result;
  logic acc_busy;
  wire [ACK_W-1:0] ack_field = acc_busy ? ACK_WAIT : ACK_OK;
  wire [ACC_W-1:0] dr_capture =
    sel_ident ? {3'h0, IDENT_VALUE} :
    sel_acc ? {acc_result, ack_field} :
    '0;
  // Chain lengths; the incoming bit enters at the top of the selected chain
  localparam logic [5:0] LEN_IDENT = 6'(TAP_BUS_W);
  localparam logic [5:0] LEN_ACC = 6'(ACC_W);
  localparam logic [5:0] LEN_BYPASS = 6'h01;
  wire [5:0] dr_len =
    sel_ident ? LEN_IDENT : (sel_acc || sel_abort) ? LEN_ACC : LEN_BYPASS;
  wire [ACC_W-1:0] dr_in_bit = {{(ACC_W-1){1'b0}}, tdi_d} << (dr_len - 6'd1);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) dr_shift <= '0;
    else if (tck_rise && state == JTSW_CAP_DR) dr_shift <= dr_capture;
    else if (tck_rise && state == JTSW_SH_DR) dr_shift <= (dr_shift >> 1) | dr_in_bit;
  end

  // Access update; result is held until the next transaction completes.
  // The result loops back one clock later, well inside the eight-to-one
  // clock ratio, so a debugger that skips the acknowledge still reads it.
  wire acc_update = tck_rise && state == JTSW_UPD_DR && sel_acc;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_request <= '0;
      acc_strobe <= 1'b0;
      acc_busy <= 1'b0;
      acc_result <= '0;
    end else begin
      acc_strobe <= acc_update && !swd_enable;
      if (acc_update) begin
        acc_request <= dr_shift[ACC_W-1:ACK_W];
        acc_busy <= 1'b1;
      end else if (acc_busy) begin
        acc_result <= acc_request;
        acc_busy <= 1'b0;
      end
    end
  end

  // TDO changes on falling TCK; driven only while shifting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (test_reset) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (state == JTSW_SH_IR) ? ir_shift[0] : dr_shift[0];
      tdo_oe <= !swd_enable && (state == JTSW_SH_IR || state == JTSW_SH_DR);
    end
  end

  // Switch detector: counts instruction passes with no bits shifted, then
  // watches for the walk from Select-IR back to Test-Logic-Reset. Any data
  // scan in between breaks the count, so ordinary traffic rarely trips it.
  logic [1:0] empty_passes;
  logic ir_shifted;
  wire ir_pass_end = tck_rise && state == JTSW_UPD_IR;
  wire pass_counted = empty_passes == 2'h2;
  wire preamble_exit = tck_rise && state == JTSW_SEL_IR && tms_d && pass_counted;
  wire dr_touched = tck_rise && (state == JTSW_SH_DR || state == JTSW_CAP_DR);
  wire [1:0] next_passes =
    ir_shifted ? 2'h0 : (pass_counted ? 2'h2 : empty_passes + 2'h1);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      empty_passes <= '0;
      ir_shifted <= 1'b0;
      swd_enable <= 1'b0;
    end else begin
      if (tck_rise && state == JTSW_CAP_IR) ir_shifted <= 1'b0;
      else if (tck_rise && state == JTSW_SH_IR) ir_shifted <= 1'b1;
      if (ir_pass_end) empty_passes <= next_passes;
      else if (dr_touched) empty_passes <= '0;
      if (preamble_exit) swd_enable <= 1'b1;
    end
  end

  // Pad configuration and status over Avalon-MM. Every access takes one wait
  // state: waitrequest drops for the cycle after the request is seen.
  wire bus_req = avs_read || avs_write;
  wire hit_pad = avs_address == REG_PAD;
  wire hit_status = avs_address == REG_STATUS;
  wire hit_acc = avs_address == REG_ACC;
  wire wr_pad = avs_write && hit_pad && !avs_waitrequest;
  wire [31:0] pad_word = {19'h0, pad_pullup_enable, 3'h0, pad_alt_function_select};
  wire [31:0] status_word = {20'h0, ir, state, 3'h0, swd_enable};
  wire [31:0] rd_mux =
    hit_pad ? pad_word :
    hit_status ? status_word :
    hit_acc ? acc_request : 32'h0000_0000;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pad_alt_function_select <= PAD_RESET;
      pad_pullup_enable <= PAD_RESET;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && bus_req);
      // Writes land on the edge that completes the transfer for the master
      if (wr_pad) begin
        pad_alt_function_select <= avs_writedata[PAD_SEL_LSB +: PAD_N];
        pad_pullup_enable <= avs_writedata[PAD_PU_LSB +: PAD_N];
      end
      // Read data is taken a cycle early so it stands when waitrequest drops
      if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end
endmodule // jtsw_tap
`default_nettype wire

// ### src/jtsw_pkg.sv
// Package of constants for the test access port with serial-wire switch
package jtsw_pkg;
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_INTEST = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_ABORT = 4'h8;
  localparam logic [3:0] IR_DPACC = 4'hA;
  localparam logic [3:0] IR_APACC = 4'hB;
  localparam logic [3:0] IR_IDENT = 4'hE;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int ACC_W = 35;
  localparam int ABORT_W = 35;
  localparam int ACK_W = 3;
  localparam logic [2:0] ACK_OK = 3'h2;
  localparam logic [2:0] ACK_WAIT = 3'h1;
  localparam int TAP_BUS_W = 32;
  localparam int AV_ADDR_W = 4;
  localparam logic [3:0] REG_PAD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ACC = 4'h8;
  localparam int PAD_N = 5;
  localparam logic [4:0] PAD_RESET = 5'h1F;
  localparam int PAD_SEL_LSB = 0;
  localparam int PAD_PU_LSB = 8;
  localparam int ST_SWD = 0;
  localparam int ST_TAP_LSB = 4;
  localparam int ST_IR_LSB = 8;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    JTSW_TLR, JTSW_RTI, JTSW_SEL_DR, JTSW_CAP_DR, JTSW_SH_DR, JTSW_EX1_DR,
    JTSW_PA_DR, JTSW_EX2_DR, JTSW_UPD_DR, JTSW_SEL_IR, JTSW_CAP_IR,
    JTSW_SH_IR, JTSW_EX1_IR, JTSW_PA_IR, JTSW_EX2_IR, JTSW_UPD_IR
  } jtsw_tap_t;
endpackage

// ### testbench/jtsw_tap_chk.sv
// Port checks for the test port
`timescale 1ns/1ps
`default_nettype none
module jtsw_tap_chk
  import jtsw_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset
  input wire logic trst_n, // Test reset
  input wire logic tdo_oe, // Out enable
  input wire logic swd_enable, // Serial-wire
  input wire logic [4:0] pad_alt_function_select, // Select
  input wire logic [4:0] pad_pullup_enable, // Pull-ups
  input wire logic acc_strobe, // Update pulse
  input wire logic [3:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Data
  input wire logic avs_waitrequest // Wait
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  wire pad_wr = avs_write && !avs_waitrequest && avs_address == REG_PAD;
  wire [12:0] wd = avs_writedata[12:0];
  wire [12:0] pads = {pad_pullup_enable, 3'h0, pad_alt_function_select};
  a_pad_reset: assert property ($rose(nrst) |-> pads == 13'h1F1F)
    else $error("pads not at reset");
  a_pad_write: assert property (pad_wr |=> pads == ($past(wd) & 13'h1F1F))
    else $error("pad write lost");
  a_pad_hold: assert property (!pad_wr |=> $stable(pads))
    else $error("pads moved");
  a_swd_sticky: assert property (swd_enable |=> swd_enable)
    else $error("serial-wire lost");
  a_swd_quiet: assert property (swd_enable |-> !tdo_oe)
    else $error("data out driven");
  a_trst_idle: assert property (!trst_n [*5] |-> !tdo_oe && !acc_strobe)
    else $error("test reset ignored");
  a_strobe_one: assert property (acc_strobe |=> !acc_strobe)
    else $error("strobe too long");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus not answered");
endmodule // jtsw_tap_chk
bind jtsw_tap jtsw_tap_chk jtsw_tap_chk_i (.*);
`default_nettype wire

// ### testbench/jtsw_dbg.sv
// Behavioural debugger driving the test pins
`timescale 1ns/1ps
`default_nettype none
module jtsw_dbg (
  input wire logic clock, // Pacing clock
  input wire logic tdo, // Pin level of data out
  output logic tck = 1'b1, // Idles high
  output logic tms = 1'b1, // Mode select
  output logic tdi = 1'b1 // Data in
);
  // LSB first, 400 ns a bit; tdo is taken just before each rise
  task automatic xfer(input logic [63:0] m, input logic [63:0] d, input int n,
    output logic [63:0] q);
    q = 64'h0;
    for (int i = 0; i < n; i++) begin
      tck <= 1'b0;
      tms <= m[i];
      tdi <= d[i];
      repeat (4) @(posedge clock);
      q[i] = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule // jtsw_dbg
`default_nettype wire

// ### testbench/jtag_tap_swd_switch_tb_top.sv
// Self-checking bench for the test port
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_swd_switch_tb_top;
  import jtsw_pkg::*;
  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d;} jtsw_row_t;
  logic clock = 1'b0, nrst = 1'b0, trst_n = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, swd_enable, acc_strobe, avs_waitrequest;
  logic [4:0] pad_alt_function_select, pad_pullup_enable;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, acc_request, avs_readdata, q;
  logic [63:0] r;
  int err_count = 0, n_compared = 0;
  jtsw_row_t rows [6] = '{'{1'h1, REG_PAD, 32'h0}, '{1'h0, REG_PAD, 32'h0},
    '{1'h0, 4'hC, 32'h0}, '{1'h1, REG_PAD, 32'h1F1F}, '{1'h0, REG_PAD, 32'h1F1F},
    '{1'h1, REG_PAD, 32'h0203}};
  jtsw_tap #(.IDENT_VALUE(32'hA5C3_0F69)) jtsw_tap_i (.*); // Arbitrary value
  jtsw_dbg jtsw_dbg_i (.clock(clock), .tdo(tdo_oe ? tdo : 1'b1), .tck(tck),
    .tms(tms), .tdi(tdi));
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    if (g !== e) err_count++;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // From idle: capture, shift b bits, update, back to idle
  // The instruction path passes one more state before its capture
  task automatic scan(input logic ir, input logic [63:0] d, input int b);
    int off;
    off = ir ? 4 : 3;
    jtsw_dbg_i.xfer((ir ? 64'h3 : 64'h1) | (64'h3 << (b + off - 1)), d << off,
      b + off + 2, r);
    r = r >> off;
  endtask
  task automatic rst();
    nrst <= 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    chk({pad_alt_function_select, pad_pullup_enable, swd_enable}, 11'h7FE);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[11:0], 12'hE00);
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #25 clock = ~clock;
  initial begin
    #1_000_000;
    err_count++;
    final_report();
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].d);
    end
    jtsw_dbg_i.xfer(64'h0, 64'h0, 1, r);
    scan(1'b0, 64'h0, 32);
    chk(r[31:0], 32'hA5C3_0F69);
    scan(1'b1, 64'h3, 4);
    chk(r[3:0], 4'h1);
    scan(1'b0, 64'hB4, 8);
    chk(r[7:0], 8'h68);
    scan(1'b1, IR_DPACC, 4);
    scan(1'b0, {32'hCAFE_0123, 3'h0}, 35);
    chk({acc_request, r[2:0]}, {32'hCAFE_0123, ACK_OK});
    scan(1'b0, 64'h0, 35);
    chk(r[34:0], {32'hCAFE_0123, ACK_OK});
    jtsw_dbg_i.xfer(64'h1F2, 64'h0, 9, r);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[11:0], 12'hE00);
    jtsw_dbg_i.xfer(64'h0, 64'h0, 1, r);
    trst_n <= 1'b0;
    repeat (8) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[7:4], 4'h0);
    trst_n <= 1'b1;
    repeat (4) @(posedge clock);
    jtsw_dbg_i.xfer(64'hEDB6, 64'h0, 16, r);
    repeat (4) @(posedge clock);
    chk(swd_enable, 1'b1);
    scan(1'b0, 64'h0, 8);
    chk(r[7:0], 8'hFF);
    rst();
    final_report();
  end
endmodule // jtag_tap_swd_switch_tb_top
`default_nettype wire
